// file: design/shb_defs.svh
// Offsets, field positions, reset values and rate figures of the serial port
`ifndef SHB_DEFS_SVH
`define SHB_DEFS_SVH
// ************************************************************
// Register byte offsets
// ************************************************************
`define SHB_ADR_CTRL 4'h0
`define SHB_ADR_STAT 4'h4
`define SHB_ADR_DATA 4'h8
// ************************************************************
// Field positions
// ************************************************************
`define SHB_C_SELECT_PIN_IGNORE 7
`define SHB_C_EN 6
`define SHB_C_LSB 5
`define SHB_C_MASTER_SELECT 4
`define SHB_C_CLOCK_POLARITY 3
`define SHB_C_CLOCK_PHASE 2
`define SHB_S_DONE 7
`define SHB_S_WRITE_COLLISION_FLAG 6
`define SHB_S_FULL 5
`define SHB_S_BUSY 4
`define SHB_S_RATE2 0
// ************************************************************
// Reset values and rate figures
// ************************************************************
`define SHB_CTRL_RST 8'h04
`define SHB_SYS_DIV_MIN 7'h04
`define SHB_OVF_DIV 7'h06
`define SHB_BITS 4'h8
`endif

// file: design/shb_pkg.sv
// Types shared by the serial port modules
`default_nettype none
package shb_pkg;
  typedef enum logic [2:0] {
    SHB_IDLE = 3'b001,
    SHB_LEAD = 3'b010,
    SHB_SHIFT = 3'b100
  } shb_fsm_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic rate2;
    logic done;
    logic write_collision_flag;
    logic [7:0] hold;
    logic hold_full;
    logic [7:0] output_shifter;
    logic osr_full;
    logic [7:0] rx;
    shb_fsm_t fsm;
    logic [3:0] nsamp;
    logic latch;
    logic pend;
    logic sck_prev;
    logic sck_o;
    logic sck_oe;
    logic sdo;
    logic mosi_oe;
    logic miso_oe;
    logic ack;
    logic [7:0] dat;
  } shb_state_t;

  typedef struct packed {
    logic [6:0] cnt;
    logic tick;
  } shb_div_t;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
  } shb_sync_t;
endpackage : shb_pkg
`default_nettype wire

// file: design/shb_div_if.sv
// Carrier between the port engine and its bit-rate divider
`default_nettype none
interface shb_div_if;
  logic [2:0] rate;
  logic run;
  logic uart_ovf;
  logic t3_ovf;
  logic tick;
  modport ctl (output rate, output run, output uart_ovf, output t3_ovf, input tick);
  modport div (input rate, input run, input uart_ovf, input t3_ovf, output tick);
endinterface : shb_div_if
`default_nettype wire

// file: design/shb_sync.sv
// Two-stage synchroniser for the four serial pins
`default_nettype none
module shb_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] pin_i,
  output logic [3:0] sync_o
);
  shb_pkg::shb_sync_t q;
  shb_pkg::shb_sync_t d;

  always_comb begin
    d = q;
    d.s1 = pin_i;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_o = q.s2;
endmodule : shb_sync
`default_nettype wire

// file: design/shb_rate_div.sv
// Half-bit enable generator for the master clock
`include "shb_defs.svh"
`default_nettype none
module shb_rate_div (
  input wire logic clk_i,
  input wire logic rst_i,
  shb_div_if.div dv
);
  shb_pkg::shb_div_t q;
  shb_pkg::shb_div_t d;
  logic ovf;
  logic [6:0] lim;

  // Half a bit: divide/2 system cycles, or three overflow pulses
  always_comb begin
    d = q;
    d.tick = 1'b0;
    ovf = dv.rate[0] ? dv.t3_ovf : dv.uart_ovf;
    // Halve before shifting: divide/128 would overflow the 7-bit limit
    lim = (dv.rate[2:1] == 2'b11) ? (`SHB_OVF_DIV >> 1)
        : 7'(`SHB_SYS_DIV_MIN >> 1) << dv.rate;
    if (!dv.run) begin
      d.cnt = '0;
    end else if (dv.rate[2:1] != 2'b11 || ovf) begin
      if (q.cnt >= lim - 7'h01) begin
        d.cnt = '0;
        d.tick = 1'b1;
      end else begin
        d.cnt = q.cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dv.tick = q.tick;
endmodule : shb_rate_div
`default_nettype wire

// file: design/shb_port.sv
// Master/slave serial port with transmit holding buffer, Wishbone registers
//
// Local design decisions: the register offsets and the Wishbone register port.
`include "shb_defs.svh"
`default_nettype none
module shb_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_o,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_o,
  input wire logic ss_n_i,
  input wire logic ss_pin_is_output_i,
  input wire logic uart1_baud_overflow_i,
  input wire logic timer3_overflow_i,
  input wire logic timer3_low_overflow_i,
  input wire logic timer3_split_i,
  output logic transfer_done_o
);
  // ************************************************************
  // State, pin synchronisers and divider
  // ************************************************************
  localparam shb_pkg::shb_state_t ST_RST = '{
    ctrl: `SHB_CTRL_RST,
    fsm: shb_pkg::SHB_IDLE,
    default: '0
  };

  shb_pkg::shb_state_t q;
  shb_pkg::shb_state_t d;
  logic [3:0] pins_s;
  logic sck_s;
  logic mosi_s;
  logic miso_s;
  logic ss_s;
  logic req;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_data;
  logic en;
  logic select_pin_ignore;
  logic master_select;
  logic clock_polarity;
  logic clock_phase;
  logic lsb;
  logic mode_chg;
  logic fin;
  logic edge_hit;
  logic lead;
  logic sample;
  logic rx_bit;
  logic busy;
  shb_div_if dv ();

  shb_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({sck_i, mosi_i, miso_i, ss_n_i}),
    .sync_o(pins_s)
  );

  shb_rate_div u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .dv(dv)
  );

  assign sck_s = pins_s[3];
  assign mosi_s = pins_s[2];
  assign miso_s = pins_s[1];
  assign ss_s = pins_s[0];
  assign dv.rate = {q.rate2, q.ctrl[1:0]};
  assign dv.run = (q.fsm != shb_pkg::SHB_IDLE);
  assign dv.uart_ovf = uart1_baud_overflow_i;
  // Split timer mode takes the low-byte overflow
  assign dv.t3_ovf = timer3_split_i ? timer3_low_overflow_i : timer3_overflow_i;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic head_bit(input logic [7:0] sr, input logic lsb_first);
    head_bit = lsb_first ? sr[0] : sr[7];
  endfunction : head_bit

  // Out goes the head bit, in comes the far end's bit
  function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic b,
                                          input logic lsb_first);
    shift_in = lsb_first ? {b, sr[7:1]} : {sr[6:0], b};
  endfunction : shift_in

  assign req = wb_cyc_i && wb_stb_i && !q.ack;
  assign wr_ctrl = req && wb_we_i && wb_sel_i[0] && wb_adr_i == `SHB_ADR_CTRL;
  assign wr_stat = req && wb_we_i && wb_sel_i[0] && wb_adr_i == `SHB_ADR_STAT;
  assign wr_data = req && wb_we_i && wb_sel_i[0] && wb_adr_i == `SHB_ADR_DATA;
  assign en = q.ctrl[`SHB_C_EN];
  assign select_pin_ignore = q.ctrl[`SHB_C_SELECT_PIN_IGNORE];
  assign master_select = q.ctrl[`SHB_C_MASTER_SELECT];
  assign clock_polarity = q.ctrl[`SHB_C_CLOCK_POLARITY];
  assign clock_phase = q.ctrl[`SHB_C_CLOCK_PHASE];
  assign lsb = q.ctrl[`SHB_C_LSB];
  // Buffered byte counts too, so no idle gap shows between two bytes
  assign busy = (q.fsm != shb_pkg::SHB_IDLE) || q.osr_full || q.hold_full;
  // Select pin only counts when enabled, not ignored, not driven by us
  assign mode_chg = en && !select_pin_ignore && master_select && !ss_s && !ss_pin_is_output_i;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    d = q;
    d.ack = 1'b0;
    fin = 1'b0;
    edge_hit = 1'b0;
    lead = 1'b0;
    sample = 1'b0;
    rx_bit = master_select ? miso_s : mosi_s;
    d.sck_prev = sck_s;

    // Wishbone slave: answer one cycle after the request
    if (req) begin
      d.ack = 1'b1;
      case (wb_adr_i)
        `SHB_ADR_CTRL: d.dat = q.ctrl;
        `SHB_ADR_STAT: d.dat = {q.done, q.write_collision_flag, q.hold_full, busy, 3'h0, q.rate2};
        `SHB_ADR_DATA: d.dat = q.rx;
        default: d.dat = 8'h00;
      endcase
    end
    if (wr_ctrl) begin
      d.ctrl = wb_dat_i[7:0];
    end
    if (wr_stat) begin
      d.rate2 = wb_dat_i[`SHB_S_RATE2];
      if (wb_dat_i[`SHB_S_DONE]) begin
        d.done = 1'b0;
      end
      if (wb_dat_i[`SHB_S_WRITE_COLLISION_FLAG]) begin
        d.write_collision_flag = 1'b0;
      end
    end
    if (wr_data) begin
      if (q.hold_full) begin
        d.write_collision_flag = 1'b1;
      end else begin
        d.hold = wb_dat_i[7:0];
        d.hold_full = 1'b1;
      end
    end

    // Holding buffer drops into an idle, empty shifter
    if (q.hold_full && !q.osr_full && q.fsm == shb_pkg::SHB_IDLE) begin
      d.output_shifter = q.hold;
      d.osr_full = 1'b1;
      d.hold_full = 1'b0;
    end

    // Edge sources: own divider as master, synchronised pin as slave
    if (master_select) begin
      if (q.fsm == shb_pkg::SHB_SHIFT && dv.tick) begin
        edge_hit = 1'b1;
        lead = (q.sck_o == clock_polarity);
        d.sck_o = ~q.sck_o;
      end
    end else if (en && (select_pin_ignore || !ss_s) && sck_s != q.sck_prev) begin
      edge_hit = 1'b1;
      lead = (sck_s != clock_polarity);
      d.fsm = shb_pkg::SHB_SHIFT;
    end
    // Phase 0 samples on leading edges, phase 1 on trailing edges
    sample = edge_hit && (lead != clock_phase);

    if (edge_hit) begin
      if (sample) begin
        d.nsamp = q.nsamp + 4'h1;
        if (clock_phase && q.nsamp == `SHB_BITS - 4'h1) begin
          d.output_shifter = shift_in(d.output_shifter, rx_bit, lsb);
          fin = 1'b1;
        end else begin
          d.latch = rx_bit;
          d.pend = 1'b1;
        end
      end else if (q.pend) begin
        d.output_shifter = shift_in(d.output_shifter, q.latch, lsb);
        d.pend = 1'b0;
        fin = !clock_phase && q.nsamp == `SHB_BITS;
      end
    end

    // Byte boundary: stop the clock, hand the byte to the reader
    if (fin) begin
      d.rx = d.output_shifter;
      d.osr_full = 1'b0;
      d.done = 1'b1;
      d.fsm = shb_pkg::SHB_IDLE;
      d.nsamp = 4'h0;
      d.pend = 1'b0;
    end

    // Master start and its half-bit lead-in
    case (q.fsm)
      shb_pkg::SHB_IDLE: begin
        if (en && master_select && q.osr_full && !mode_chg) begin
          d.fsm = shb_pkg::SHB_LEAD;
        end
      end
      shb_pkg::SHB_LEAD: begin
        if (dv.tick) begin
          d.fsm = shb_pkg::SHB_SHIFT;
        end
      end
      shb_pkg::SHB_SHIFT: begin
      end
      default: begin
        d.fsm = shb_pkg::SHB_IDLE;
      end
    endcase

    // A deselected slave drops any partial byte
    if (!master_select && !select_pin_ignore && ss_s && q.fsm != shb_pkg::SHB_IDLE) begin
      d.fsm = shb_pkg::SHB_IDLE;
      d.nsamp = 4'h0;
      d.pend = 1'b0;
    end

    // Mode change wins over software's master bit
    if (mode_chg) begin
      d.ctrl[`SHB_C_MASTER_SELECT] = 1'b0;
      d.done = 1'b1;
      d.fsm = shb_pkg::SHB_IDLE;
      d.nsamp = 4'h0;
      d.pend = 1'b0;
    end

    if (!d.ctrl[`SHB_C_EN]) begin
      d.fsm = shb_pkg::SHB_IDLE;
      d.nsamp = 4'h0;
      d.pend = 1'b0;
    end

    // Pin drivers, taken from the next state and, for the miso enable, the synchronised select pin
    if (d.fsm == shb_pkg::SHB_IDLE) begin
      d.sck_o = d.ctrl[`SHB_C_CLOCK_POLARITY];
    end
    d.sdo = head_bit(d.output_shifter, d.ctrl[`SHB_C_LSB]);
    d.sck_oe = d.ctrl[`SHB_C_EN] && d.ctrl[`SHB_C_MASTER_SELECT]
               && (d.ctrl[`SHB_C_SELECT_PIN_IGNORE] || d.fsm != shb_pkg::SHB_IDLE);
    d.mosi_oe = d.sck_oe;
    d.miso_oe = d.ctrl[`SHB_C_EN] && !d.ctrl[`SHB_C_MASTER_SELECT]
                && (d.ctrl[`SHB_C_SELECT_PIN_IGNORE] || !ss_s);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o = {24'h000000, q.dat};
  assign wb_ack_o = q.ack;
  assign sck_o = q.sck_o;
  assign sck_oe_o = q.sck_oe;
  assign mosi_o = q.sdo;
  assign mosi_oe_o = q.mosi_oe;
  assign miso_o = q.sdo;
  assign miso_oe_o = q.miso_oe;
  assign transfer_done_o = q.done;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_sel_as_master;
    en && !select_pin_ignore && master_select && !ss_pin_is_output_i ##0 !ss_s;
  endsequence

  sequence s_full_write;
    wr_data && q.hold_full;
  endsequence

  a_mode_change: assert property (s_sel_as_master |=> !master_select && q.done
                                  && q.fsm == shb_pkg::SHB_IDLE)
    else $error("select low as master did not force slave");

  a_write_collision_flag_set: assert property (s_full_write |=> q.write_collision_flag)
    else $error("collision flag not set");

  a_hold_kept: assert property (s_full_write |=> q.hold == $past(q.hold))
    else $error("colliding write changed the buffer");

  a_hold_load: assert property (wr_data && !q.hold_full |=> q.hold_full
                                && q.hold == $past(wb_dat_i[7:0]))
    else $error("holding buffer not loaded");

  a_osr_move: assert property (q.hold_full && !q.osr_full && q.fsm == shb_pkg::SHB_IDLE
                               |=> !q.hold_full && q.osr_full
                               && q.output_shifter == $past(q.hold))
    else $error("buffered byte not moved to shifter");

  a_done_clear: assert property (wr_stat && wb_dat_i[`SHB_S_DONE] && !fin && !mode_chg
                                 |=> !q.done)
    else $error("done flag not cleared");

  a_write_collision_flag_clear: assert property (wr_stat && wb_dat_i[`SHB_S_WRITE_COLLISION_FLAG] && !(wr_data && q.hold_full)
                                 |=> !q.write_collision_flag)
    else $error("collision flag not cleared");

  a_off_released: assert property (!en |-> !sck_oe_o && !mosi_oe_o && !miso_oe_o)
    else $error("pins driven while disabled");

  a_master_start: assert property (en && master_select && q.osr_full && !mode_chg
                                   && q.fsm == shb_pkg::SHB_IDLE
                                   |=> q.fsm == shb_pkg::SHB_LEAD ##1 sck_oe_o)
    else $error("master write did not start transfer");

  a_idle_clock: assert property ((q.fsm == shb_pkg::SHB_IDLE && $stable(clock_polarity))[*2]
                                 |-> sck_o == clock_polarity)
    else $error("serial clock not at idle level");

  a_byte_fast: assert property (q.fsm == shb_pkg::SHB_LEAD && dv.rate == 3'h0 && en
                                && master_select && !mode_chg
                                |-> ##[30:40] q.done || !en || !master_select)
    else $error("fastest byte did not finish in time");
endmodule : shb_port
`default_nettype wire

// file: test/shb_peer.sv
// Behavioural serial slave that stands on the far side of the port
`default_nettype none
module shb_peer (
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic sel_n_i,
  input wire logic clock_polarity_i,
  input wire logic clock_phase_i,
  input wire logic lsb_i,
  input wire logic [7:0] tx_i,
  output logic miso_o,
  output logic [7:0] rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int n = 0;
  int idx;
  logic prev = 1'b0;
  logic [7:0] sr = 8'h00;
  assign rx_o = sr;
  initial miso_o = 1'b0;
  // Unselected or spent line shows the inverse of its last bit
  always @(sck_i or sel_n_i) begin
    if (sel_n_i) begin
      n = 0;
    end else if (sck_i !== prev) begin
      if ((sck_i != clock_polarity_i) != clock_phase_i) begin
        sr = lsb_i ? {mosi_i, sr[7:1]} : {sr[6:0], mosi_i};
      end else begin
        n = n + 1;
      end
    end
    prev = sck_i;
    idx = clock_phase_i ? n - 1 : n;
    if (sel_n_i || idx < 0 || idx > 7) begin
      miso_o = ~miso_o;
    end else begin
      miso_o = lsb_i ? tx_i[idx] : tx_i[7-idx];
    end
  end
endmodule : shb_peer
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench of the serial port
`include "shb_defs.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [7:0] wdat = 8'h00;
  logic [31:0] rdat;
  logic ack, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, pmiso;
  logic done_o;
  logic msck = 1'b0;
  logic mmosi = 1'b0;
  logic t3 = 1'b0;
  logic split = 1'b0;
  logic ss_n = 1'b1;
  logic psel_n = 1'b1;
  logic pcpol = 1'b0;
  logic pcpha = 1'b0;
  logic plsb = 1'b0;
  logic [7:0] ptx = 8'h00;
  logic [7:0] prx, r;
  logic ovf = 1'b0;
  logic [1:0] ovf_cnt = 2'h0;
  int mismatches = 0;
  int checked = 0;
  // Far master's clock and data; its clock rests low like a pull-down
  wire logic sck_w = sck_oe ? sck_o : msck;
  wire logic mosi_w = mosi_oe ? mosi_o : (ss_n ? ~mosi_o : mmosi);
  wire logic miso_w = miso_oe ? miso_o : pmiso;

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    ovf_cnt <= (ovf_cnt == 2'h2) ? 2'h0 : ovf_cnt + 2'h1;
    ovf <= (ovf_cnt == 2'h2);
    t3 <= ~t3;
  end

  shb_port dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i({24'h000000, wdat}),
    .wb_dat_o(rdat), .wb_ack_o(ack), .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe),
    .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe), .miso_i(miso_w),
    .miso_o(miso_o), .miso_oe_o(miso_oe), .ss_n_i(ss_n), .ss_pin_is_output_i(1'b0),
    .uart1_baud_overflow_i(ovf), .timer3_overflow_i(t3),
    .timer3_low_overflow_i(ovf), .timer3_split_i(split), .transfer_done_o(done_o));
  shb_peer peer_u (.sck_i(sck_w), .mosi_i(mosi_w), .sel_n_i(psel_n), .clock_polarity_i(pcpol),
    .clock_phase_i(pcpha), .lsb_i(plsb), .tx_i(ptx), .miso_o(pmiso), .rx_o(prx));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task automatic timeout;
    mismatches++;
    $display("wait ran out at %0t", $time);
    give_verdict();
  endtask : timeout

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) timeout();
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      wb(1'b0, `SHB_ADR_STAT, 8'h00);
      n++;
    end while (r[4] !== 1'b0 && n < 1000);
    if (r[4] !== 1'b0) timeout();
  endtask : wait_idle

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset;
    wb(1'b0, `SHB_ADR_CTRL, 8'h00);
    chk(r, `SHB_CTRL_RST);
    wb(1'b0, `SHB_ADR_STAT, 8'h00);
    chk(r, 8'h00);
    chk({5'h00, sck_oe, mosi_oe, miso_oe}, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_rates;
    int n;
    int k;
    for (int c = 0; c < 9; c++) begin
      k = (c > 7) ? 7 : c;
      split <= (c > 7);
      wb(1'b1, `SHB_ADR_CTRL, 8'hD0 | 8'(k & 3));
      wb(1'b1, `SHB_ADR_STAT, 8'hC0 | 8'(k >> 2));
      wb(1'b1, `SHB_ADR_DATA, 8'h5A);
      n = 0;
      while (sck_o === 1'b0 && n < 300) begin
        @(posedge clk_i);
        n++;
      end
      n = 0;
      while (sck_o === 1'b1 && n < 300) begin
        @(posedge clk_i);
        n++;
      end
      chk(8'(n), (c < 6) ? 8'h02 << c : (c == 7) ? 8'h06 : 8'h09);
      chk({6'h00, sck_oe, mosi_oe}, 8'h03);
      wait_idle();
    end
    $display("test rates done");
  endtask : t_rates

  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      psel_n <= 1'b1;
      pcpol <= m[1];
      pcpha <= m[0];
      plsb <= m[0] ^ m[1];
      ptx <= 8'h3C + 8'(m);
      wb(1'b1, `SHB_ADR_CTRL, 8'hD2 | (8'(m[0] ^ m[1]) << 5) | (8'(m) << 2));
      wb(1'b1, `SHB_ADR_STAT, 8'hC0);
      psel_n <= 1'b0;
      wb(1'b1, `SHB_ADR_DATA, 8'hA5 ^ 8'(m));
      wait_idle();
      chk(prx, 8'hA5 ^ 8'(m));
      wb(1'b0, `SHB_ADR_DATA, 8'h00);
      chk(r, 8'h3C + 8'(m));
      chk({7'h00, sck_o}, {7'h00, m[1]});
      wb(1'b0, `SHB_ADR_STAT, 8'h00);
      chk(r & 8'h80, 8'h80);
    end
    $display("test modes done");
  endtask : t_modes

  task automatic t_collide;
    psel_n <= 1'b1;
    pcpol <= 1'b0;
    pcpha <= 1'b0;
    plsb <= 1'b0;
    wb(1'b1, `SHB_ADR_CTRL, 8'hD2);
    wb(1'b1, `SHB_ADR_STAT, 8'hC0);
    psel_n <= 1'b0;
    wb(1'b1, `SHB_ADR_DATA, 8'h11);
    wb(1'b1, `SHB_ADR_DATA, 8'h22);
    wb(1'b0, `SHB_ADR_STAT, 8'h00);
    chk(r & 8'h30, 8'h30);
    wb(1'b1, `SHB_ADR_DATA, 8'h33);
    wb(1'b0, `SHB_ADR_STAT, 8'h00);
    chk(r & 8'h60, 8'h60);
    wb(1'b1, `SHB_ADR_STAT, 8'h40);
    wb(1'b0, `SHB_ADR_STAT, 8'h00);
    chk(r & 8'h40, 8'h00);
    wait_idle();
    chk(prx, 8'h22);
    $display("test collision done");
  endtask : t_collide

  task automatic t_slave;
    logic [7:0] got;
    logic [7:0] mtx;
    got = 8'h00;
    mtx = 8'h96;
    wb(1'b1, `SHB_ADR_CTRL, 8'h40);
    wb(1'b1, `SHB_ADR_STAT, 8'hC0);
    wb(1'b1, `SHB_ADR_DATA, 8'hC3);
    ss_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(1'b0, `SHB_ADR_STAT, 8'h00);
    chk(r & 8'hB0, 8'h10);
    chk({7'h00, miso_oe}, 8'h01);
    for (int i = 7; i >= 0; i--) begin
      mmosi <= mtx[i];
      msck <= 1'b0;
      repeat (8) @(posedge clk_i);
      got[i] = miso_w;
      msck <= 1'b1;
      repeat (8) @(posedge clk_i);
    end
    msck <= 1'b0;
    repeat (8) @(posedge clk_i);
    ss_n <= 1'b1;
    chk(got, 8'hC3);
    chk({7'h00, done_o}, 8'h01);
    wb(1'b0, `SHB_ADR_DATA, 8'h00);
    chk(r, 8'h96);
    wb(1'b0, `SHB_ADR_STAT, 8'h00);
    chk(r & 8'hB0, 8'h80);
    $display("test slave done");
  endtask : t_slave

  task automatic t_select;
    psel_n <= 1'b1;
    wb(1'b1, `SHB_ADR_STAT, 8'hC0);
    wb(1'b1, `SHB_ADR_CTRL, 8'h50);
    wb(1'b0, `SHB_ADR_CTRL, 8'h00);
    chk({5'h00, sck_oe, mosi_oe, miso_oe}, 8'h00);
    ss_n <= 1'b0;
    wb(1'b0, `SHB_ADR_CTRL, 8'h00);
    wb(1'b0, `SHB_ADR_CTRL, 8'h00);
    chk(r, 8'h40);
    chk({5'h00, sck_oe, mosi_oe, miso_oe}, 8'h01);
    wb(1'b0, `SHB_ADR_STAT, 8'h00);
    chk(r & 8'h80, 8'h80);
    ss_n <= 1'b1;
    wb(1'b0, `SHB_ADR_CTRL, 8'h00);
    wb(1'b0, `SHB_ADR_CTRL, 8'h00);
    chk({7'h00, miso_oe}, 8'h00);
    wb(1'b1, `SHB_ADR_STAT, 8'h80);
    wb(1'b0, `SHB_ADR_STAT, 8'h00);
    chk(r & 8'h80, 8'h00);
    wb(1'b1, `SHB_ADR_CTRL, 8'h50);
    wb(1'b0, `SHB_ADR_CTRL, 8'h00);
    chk(r, 8'h50);
    wb(1'b1, `SHB_ADR_CTRL, 8'h10);
    ss_n <= 1'b0;
    wb(1'b0, `SHB_ADR_CTRL, 8'h00);
    wb(1'b0, `SHB_ADR_CTRL, 8'h00);
    chk(r, 8'h10);
    chk({5'h00, sck_oe, mosi_oe, miso_oe}, 8'h00);
    $display("test select done");
  endtask : t_select

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_rates();
    t_modes();
    t_collide();
    t_slave();
    t_select();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
